// *** gauge_pkg.sv ***
package gauge_pkg;
	localparam logic [6:0] DEV_ADDR = 7'h0b;
	localparam logic [7:0] CMD_SAMPLED_INIT = 8'h04;
	localparam logic [7:0] CMD_THERM_B = 8'h06;
	localparam logic [7:0] CMD_IMM_INIT = 8'h07;
	localparam logic [7:0] CMD_TEMP = 8'h08;
	localparam logic [7:0] CMD_VOLT = 8'h09;
	localparam logic [7:0] CMD_DIR = 8'h0a;
	localparam logic [7:0] CMD_IMPED = 8'h0b;
	localparam logic [7:0] CMD_LAG = 8'h0c;
	localparam logic [7:0] CMD_PCT = 8'h0d;
	localparam logic [7:0] CMD_PERMILLE = 8'h0f;
	localparam logic [7:0] CMD_VERSION = 8'h11;
	localparam logic [7:0] CMD_PROF_SEL = 8'h12;
	localparam logic [7:0] CMD_LOW_CHG = 8'h13;
	localparam logic [7:0] CMD_LOW_V = 8'h14;
	localparam logic [7:0] CMD_PWR = 8'h15;
	localparam logic [7:0] CMD_TSRC = 8'h16;
	localparam logic [7:0] CMD_PROF_CODE = 8'h1a;
	localparam logic [15:0] INIT_KEY = 16'haa55;
	localparam logic [15:0] THERM_B_RST = 16'h0d34;
	localparam logic [15:0] TEMP_RST = 16'h0ba6;
	localparam logic [15:0] TEMP_MIN = 16'h09e4;
	localparam logic [15:0] TEMP_MAX = 16'h0d04;
	localparam logic [15:0] DIR_AUTO = 16'h0000;
	localparam logic [15:0] DIR_CHARGE = 16'h0001;
	localparam logic [15:0] DIR_DISCHARGE = 16'hffff;
	localparam logic [15:0] IMPED_MAX = 16'h00ff;
	localparam logic [15:0] IMPED_RST = 16'h0000;
	localparam logic [15:0] LAG_RST = 16'h001e;
	localparam logic [15:0] PROF_MAX = 16'h0001;
	localparam logic [15:0] LOW_CHG_RST = 16'h0008;
	localparam logic [15:0] LOW_CHG_MAX = 16'h0064;
	localparam logic [15:0] LOW_V_RST = 16'h0000;
	localparam logic [15:0] PWR_OP = 16'h0001;
	localparam logic [15:0] PWR_SLEEP = 16'h0002;
	localparam logic [15:0] PWR_RST = 16'h0001;
	localparam logic [15:0] TSRC_HOST = 16'h0000;
	localparam logic [15:0] TSRC_THERM = 16'h0001;
	localparam logic [15:0] MV_EMPTY = 16'h0bb8;
	localparam logic [15:0] MV_FULL = 16'h1068;
	localparam logic [9:0] PERMILLE_FULL = 10'h3e8;
	localparam int CLK_HZ = 10_000_000;
	localparam int POR_INIT_MS = 10;
	localparam int POR_INIT_CYCLES = POR_INIT_MS * (CLK_HZ / 1000);
	localparam int INIT_MAX_US = 1500;
	localparam int INIT_MAX_CYCLES = INIT_MAX_US * (CLK_HZ / 1_000_000);
	localparam int MS_TICK_CYCLES = CLK_HZ / 1000;
	localparam int TEMP_PERIOD_MS = 1000;

	typedef struct packed {
		logic [7:0] cmd;
		logic [15:0] data;
	} wr_cmd_t;

	typedef enum logic [9:0] {
		PH_IDLE = 10'h001,
		PH_ADDR = 10'h002,
		PH_CMD = 10'h004,
		PH_WLO = 10'h008,
		PH_WHI = 10'h010,
		PH_WCRC = 10'h020,
		PH_RLO = 10'h040,
		PH_RHI = 10'h080,
		PH_RCRC = 10'h100,
		PH_SPARE = 10'h200
	} bus_phase_t;

	typedef enum logic [2:0] {
		TS_IDLE = 3'h1,
		TS_SETTLE = 3'h2,
		TS_LOAD = 3'h4
	} therm_state_t;

	// CRC-8 with polynomial x^8+x^2+x+1, zero seed, MSB first.
	function automatic logic [7:0] crc8_byte(input logic [7:0] crc,
		input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		end
		return c;
	endfunction
endpackage

// *** battery_gauge_register_bank.sv ***
module battery_gauge_register_bank
	import gauge_pkg::*;
#(
	parameter int POR_CYCLES = POR_INIT_CYCLES,
	parameter int MS_CYCLES = MS_TICK_CYCLES,
	parameter int PERIOD_MS = TEMP_PERIOD_MS,
	// Arbitrary values, not tied to any real part.
	parameter logic [15:0] CHIP_VERSION = 16'h0001,
	parameter logic [15:0] PROFILE_CODE = 16'h0301
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [15:0] cell_mv_in,
	input wire logic cell_mv_valid,
	input wire logic [15:0] thermistor_sense_input,
	input wire logic [9:0] track_permille,
	input wire logic track_valid,
	output logic thermistor_power_switch,
	output logic alarm_out_n,
	output logic gauge_running
);
	// Serial slave state.
	logic scl_q, sda_q;
	bus_phase_t phase_r, phase_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic ack_r, ack_nxt, tx_r, tx_nxt, mnack_r, mnack_nxt;
	logic sda_oe_r, oe_nxt, sda_out_r;
	logic [7:0] crc_r, crc_nxt, cmd_r, cmd_nxt, hold_r, hold_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic commit;
	wr_cmd_t wr_r;
	logic wr_stb_r;
	// Registers.
	logic [15:0] therm_b_r, temp_r, volt_r, dir_r, imped_r, lag_r;
	logic [15:0] prof_r, low_chg_r, low_v_r, pwr_r, tsrc_r;
	logic [9:0] permille_r, permille_nxt;
	logic [15:0] max_mv_r;
	logic [31:0] por_cnt_r;
	logic por_done_r;
	logic alarm_chg_r, alarm_v_r, alarm_out_n_r, running_r;
	// Thermistor scheduler.
	therm_state_t ts_r, ts_nxt;
	logic [31:0] ms_cnt_r, per_cnt_r;
	logic [15:0] settle_r;
	logic tsw_r;
	wire bus_start = scl_in & scl_q & sda_q & ~sda_in;
	wire bus_stop = scl_in & scl_q & ~sda_q & sda_in;
	wire scl_rise = scl_in & ~scl_q;
	wire scl_fall = ~scl_in & scl_q;
	wire [10:0] pm_round = {1'b0, permille_r} + 11'h005;
	wire [6:0] pct = 7'(pm_round / 11'h00a);
	logic [15:0] rd_word;
	always_comb begin
		case (cmd_r)
			CMD_THERM_B: rd_word = therm_b_r;
			CMD_TEMP: rd_word = temp_r;
			CMD_VOLT: rd_word = volt_r;
			CMD_DIR: rd_word = dir_r;
			CMD_IMPED: rd_word = imped_r;
			CMD_LAG: rd_word = lag_r;
			CMD_PCT: rd_word = {9'h000, pct};
			CMD_PERMILLE: rd_word = {6'h00, permille_r};
			CMD_VERSION: rd_word = CHIP_VERSION;
			CMD_PROF_SEL: rd_word = prof_r;
			CMD_LOW_CHG: rd_word = low_chg_r;
			CMD_LOW_V: rd_word = low_v_r;
			CMD_PWR: rd_word = pwr_r;
			CMD_TSRC: rd_word = tsrc_r;
			CMD_PROF_CODE: rd_word = PROFILE_CODE;
			default: rd_word = 16'h0000;
		endcase
	end

	// Byte to load for transmission at the end of an acknowledge slot.
	wire ld_lo = phase_r == PH_RLO;
	wire ld_hi = phase_r == PH_RHI;
	wire ld_crc = phase_r == PH_RCRC;
	wire [7:0] ld_byte = ld_lo ? rd_word[7:0] : ld_hi ? hold_r : crc_r;
	wire addr_hit = shift_r[7:1] == DEV_ADDR;
	always_comb begin
		phase_nxt = phase_r;
		bit_nxt = bit_r;
		shift_nxt = shift_r;
		ack_nxt = ack_r;
		tx_nxt = tx_r;
		oe_nxt = sda_oe_r;
		crc_nxt = crc_r;
		cmd_nxt = cmd_r;
		wdata_nxt = wdata_r;
		hold_nxt = hold_r;
		mnack_nxt = mnack_r;
		commit = 1'b0;
		if (bus_start || bus_stop) begin
			phase_nxt = bus_start ? PH_ADDR : PH_IDLE;
			bit_nxt = 4'h0;
			ack_nxt = 1'b0;
			tx_nxt = 1'b0;
			oe_nxt = 1'b0;
		end else if (scl_rise) begin
			if (ack_r) begin
				mnack_nxt = sda_in;
			end else begin
				bit_nxt = bit_r + 4'h1;
				if (!tx_r)
					shift_nxt = {shift_r[6:0], sda_in};
			end
		end else if (scl_fall) begin
			if (ack_r) begin
				ack_nxt = 1'b0;
				oe_nxt = 1'b0;
				if (tx_r && mnack_r) begin
					tx_nxt = 1'b0;
					phase_nxt = PH_IDLE;
				end else if (ld_lo || ld_hi || ld_crc) begin
					tx_nxt = 1'b1;
					oe_nxt = ~ld_byte[7];
					shift_nxt = {ld_byte[6:0], 1'b0};
					if (!ld_crc)
						crc_nxt = crc8_byte(crc_r, ld_byte);
					if (ld_lo)
						hold_nxt = rd_word[15:8];
					phase_nxt = ld_lo ? PH_RHI : ld_hi ? PH_RCRC : PH_IDLE;
				end else begin
					tx_nxt = 1'b0;
				end
			end else if (bit_r == 4'h8) begin
				bit_nxt = 4'h0;
				ack_nxt = 1'b1;
				oe_nxt = 1'b0;
				if (!tx_r) begin
					case (phase_r)
						PH_ADDR: begin
							if (addr_hit) begin
								oe_nxt = 1'b1;
								phase_nxt = shift_r[0] ? PH_RLO : PH_CMD;
								crc_nxt = crc8_byte(shift_r[0] ? crc_r : 8'h00,
									shift_r);
							end else begin
								phase_nxt = PH_IDLE;
							end
						end
						PH_CMD: begin
							oe_nxt = 1'b1;
							cmd_nxt = shift_r;
							crc_nxt = crc8_byte(crc_r, shift_r);
							phase_nxt = PH_WLO;
						end
						PH_WLO: begin
							oe_nxt = 1'b1;
							wdata_nxt[7:0] = shift_r;
							crc_nxt = crc8_byte(crc_r, shift_r);
							phase_nxt = PH_WHI;
						end
						PH_WHI: begin
							oe_nxt = 1'b1;
							wdata_nxt[15:8] = shift_r;
							crc_nxt = crc8_byte(crc_r, shift_r);
							phase_nxt = PH_WCRC;
						end
						PH_WCRC: begin
							oe_nxt = 1'b1;
							commit = shift_r == crc_r;
							phase_nxt = PH_IDLE;
						end
						default: phase_nxt = PH_IDLE;
					endcase
				end
			end else if (tx_r) begin
				oe_nxt = ~shift_r[7];
				shift_nxt = {shift_r[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			phase_r <= PH_IDLE;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			ack_r <= 1'b0;
			tx_r <= 1'b0;
			mnack_r <= 1'b1;
			sda_oe_r <= 1'b0;
			sda_out_r <= 1'b0;
			crc_r <= 8'h00;
			cmd_r <= 8'h00;
			wdata_r <= 16'h0000;
			hold_r <= 8'h00;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			phase_r <= phase_nxt;
			bit_r <= bit_nxt;
			shift_r <= shift_nxt;
			ack_r <= ack_nxt;
			tx_r <= tx_nxt;
			mnack_r <= mnack_nxt;
			sda_oe_r <= oe_nxt;
			crc_r <= crc_nxt;
			cmd_r <= cmd_nxt;
			wdata_r <= wdata_nxt;
			hold_r <= hold_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_r <= '0;
			wr_stb_r <= 1'b0;
		end else begin
			wr_stb_r <= commit;
			if (commit)
				wr_r <= '{cmd: cmd_r, data: wdata_r};
		end
	end

	// Writes out of range, read-only or undefined are dropped.
	wire [7:0] wc = wr_r.cmd;
	wire [15:0] wd = wr_r.data;
	wire host_temp = tsrc_r == TSRC_HOST;
	wire we_therm_b = wr_stb_r && wc == CMD_THERM_B;
	wire we_temp = wr_stb_r && wc == CMD_TEMP && host_temp &&
		wd >= TEMP_MIN && wd <= TEMP_MAX;
	wire we_dir = wr_stb_r && wc == CMD_DIR &&
		(wd == DIR_AUTO || wd == DIR_CHARGE || wd == DIR_DISCHARGE);
	wire we_imped = wr_stb_r && wc == CMD_IMPED && wd <= IMPED_MAX;
	wire we_lag = wr_stb_r && wc == CMD_LAG;
	wire we_prof = wr_stb_r && wc == CMD_PROF_SEL && wd <= PROF_MAX;
	wire we_low_chg = wr_stb_r && wc == CMD_LOW_CHG && wd <= LOW_CHG_MAX;
	wire we_low_v = wr_stb_r && wc == CMD_LOW_V;
	wire we_pwr = wr_stb_r && wc == CMD_PWR &&
		(wd == PWR_OP || wd == PWR_SLEEP);
	wire we_tsrc = wr_stb_r && wc == CMD_TSRC &&
		(wd == TSRC_HOST || wd == TSRC_THERM);
	wire init_imm = wr_stb_r && wc == CMD_IMM_INIT && wd == INIT_KEY;
	wire init_smp = wr_stb_r && wc == CMD_SAMPLED_INIT && wd == INIT_KEY;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			therm_b_r <= THERM_B_RST;
			dir_r <= DIR_AUTO;
			imped_r <= IMPED_RST;
			lag_r <= LAG_RST;
			prof_r <= 16'h0000;
			low_chg_r <= LOW_CHG_RST;
			low_v_r <= LOW_V_RST;
			pwr_r <= PWR_RST;
			tsrc_r <= TSRC_HOST;
		end else begin
			if (we_therm_b) therm_b_r <= wd;
			if (we_dir) dir_r <= wd;
			if (we_imped) imped_r <= wd;
			if (we_lag) lag_r <= wd;
			if (we_prof) prof_r <= wd;
			if (we_low_chg) low_chg_r <= wd;
			if (we_low_v) low_v_r <= wd;
			if (we_pwr) pwr_r <= wd;
			if (we_tsrc) tsrc_r <= wd;
		end
	end

	// Linear open-circuit voltage map between empty and full cell voltages.
	function automatic logic [9:0] mv_to_permille(input logic [15:0] mv);
		logic [31:0] num;
		num = 32'(mv - MV_EMPTY) * 32'h0000_03e8;
		if (mv <= MV_EMPTY)
			return 10'h000;
		else if (mv >= MV_FULL)
			return PERMILLE_FULL;
		else
			return 10'(num / 32'(MV_FULL - MV_EMPTY));
	endfunction
	wire running = pwr_r == PWR_OP;
	wire por_fire = !por_done_r && por_cnt_r == 32'(POR_CYCLES - 1);
	wire [15:0] peak_mv = cell_mv_in > max_mv_r ? cell_mv_in : max_mv_r;
	always_comb begin
		permille_nxt = permille_r;
		if (por_fire || init_imm)
			permille_nxt = mv_to_permille(cell_mv_in);
		else if (init_smp)
			permille_nxt = mv_to_permille(peak_mv);
		else if (track_valid && running && por_done_r) begin
			// Direction modes hold the reported value at its extreme.
			if (dir_r == DIR_CHARGE && track_permille < permille_r)
				permille_nxt = permille_r;
			else if (dir_r == DIR_DISCHARGE && track_permille > permille_r)
				permille_nxt = permille_r;
			else
				permille_nxt = track_permille;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			por_cnt_r <= 32'h0;
			por_done_r <= 1'b0;
			permille_r <= 10'h000;
			max_mv_r <= 16'h0000;
			volt_r <= 16'h0000;
		end else begin
			if (!por_done_r)
				por_cnt_r <= por_cnt_r + 32'h1;
			if (por_fire)
				por_done_r <= 1'b1;
			permille_r <= permille_nxt;
			// Peak voltage since the power-on initialisation.
			if (por_fire || (por_done_r && cell_mv_valid && running))
				max_mv_r <= peak_mv;
			if (cell_mv_valid && running)
				volt_r <= cell_mv_in;
		end
	end

	// Alarm flags with hold band at equality.
	wire [15:0] pct16 = {9'h000, pct};
	wire chg_on = low_chg_r != 16'h0000;
	wire v_on = low_v_r != 16'h0000;
	wire chg_below = chg_on && pct16 < low_chg_r;
	wire chg_above = !chg_on || pct16 > low_chg_r;
	wire v_below = v_on && volt_r < low_v_r;
	wire v_above = !v_on || volt_r > low_v_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_chg_r <= 1'b0;
			alarm_v_r <= 1'b0;
			alarm_out_n_r <= 1'b1;
			running_r <= 1'b0;
		end else begin
			alarm_chg_r <= chg_below | (alarm_chg_r & ~chg_above);
			alarm_v_r <= v_below | (alarm_v_r & ~v_above);
			alarm_out_n_r <= ~(alarm_chg_r | alarm_v_r);
			running_r <= running;
		end
	end

	// Thermistor measurement: the switch powers the divider only from the
	// start of settling to the capture cycle. Settling lasts lag_r + 1 ticks.
	// Only sleep cuts a pulse short; a source change lets it complete.
	wire therm_mode = tsrc_r == TSRC_THERM && running;
	wire ms_tick = ms_cnt_r == 32'(MS_CYCLES - 1);
	wire period_hit = ms_tick && per_cnt_r == 32'(PERIOD_MS - 1);

	always_comb begin
		case (ts_r)
			TS_IDLE: ts_nxt = (therm_mode && period_hit) ? TS_SETTLE : TS_IDLE;
			TS_SETTLE: begin
				if (!running)
					ts_nxt = TS_IDLE;
				else if (ms_tick && settle_r >= lag_r)
					ts_nxt = TS_LOAD;
				else
					ts_nxt = TS_SETTLE;
			end
			TS_LOAD: ts_nxt = TS_IDLE;
			default: ts_nxt = TS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ts_r <= TS_IDLE;
			ms_cnt_r <= 32'h0;
			per_cnt_r <= 32'h0;
			settle_r <= 16'h0000;
			tsw_r <= 1'b0;
			temp_r <= TEMP_RST;
		end else begin
			ts_r <= ts_nxt;
			ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
			if (ms_tick)
				per_cnt_r <= period_hit ? 32'h0 : per_cnt_r + 32'h1;
			if (ts_r != TS_SETTLE)
				settle_r <= 16'h0000;
			else if (ms_tick && settle_r != 16'hffff)
				settle_r <= settle_r + 16'h0001;
			tsw_r <= ts_nxt == TS_SETTLE || ts_nxt == TS_LOAD;
			if (we_temp)
				temp_r <= wd;
			else if (ts_r == TS_LOAD && tsrc_r == TSRC_THERM)
				temp_r <= thermistor_sense_input;
		end
	end

	assign sda_out = sda_out_r;
	assign sda_oe = sda_oe_r;
	assign thermistor_power_switch = tsw_r;
	assign alarm_out_n = alarm_out_n_r;
	assign gauge_running = running_r;
endmodule

// *** gauge_props.sv ***
module gauge_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic thermistor_power_switch,
	input wire logic alarm_out_n,
	input wire logic gauge_running
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence released_s;
		$rose(rst_n);
	endsequence
	sequence powered_s;
		$rose(thermistor_power_switch);
	endsequence
	// The host samples data while SCL is high, so the pin must hold there.
	chk_oe_holds_high: assert property (
		scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("sda_oe moved while scl high");
	chk_oe_moves_low: assert property (
		$changed(sda_oe) |-> !$past(scl_in))
		else $error("sda_oe moved right after scl high");
	chk_sda_open_drain: assert property (!sda_out)
		else $error("sda_out driven high");
	chk_run_after_reset: assert property (
		released_s |=> gauge_running)
		else $error("not operational after reset");
	chk_quiet_after_reset: assert property (
		released_s |-> !sda_oe && !thermistor_power_switch && alarm_out_n)
		else $error("outputs active at reset release");
	chk_alarm_when_empty: assert property (
		released_s |-> ##[1:4] !alarm_out_n)
		else $error("no alarm while charge is empty");
	chk_switch_min_on: assert property (
		powered_s |=> thermistor_power_switch [*8])
		else $error("thermistor powered too briefly");
	chk_switch_needs_run: assert property (
		thermistor_power_switch |-> gauge_running)
		else $error("thermistor powered in sleep");
endmodule
bind battery_gauge_register_bank gauge_props i_gauge_props (
	.mclk(mclk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .thermistor_power_switch(thermistor_power_switch),
	.alarm_out_n(alarm_out_n), .gauge_running(gauge_running)
);

// *** gauge_host_model.sv ***
module gauge_host_model
	import gauge_pkg::*;
(
	input wire logic mclk,
	input wire logic sda_in,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] WA = {DEV_ADDR, 1'b0};
	localparam logic [7:0] RA = {DEV_ADDR, 1'b1};
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	function automatic logic [7:0] crc(input logic [7:0] c, d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
		end
		return r;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// SDA only moves with SCL low, so no false START or STOP is seen.
	task automatic bit_io(input logic d, output logic s);
		sda = d;
		tick(2);
		scl = 1'b1;
		tick(3);
		s = sda_in;
		tick(1);
		scl = 1'b0;
		tick(2);
	endtask
	task automatic start();
		sda = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(3);
		sda = 1'b0;
		tick(3);
		scl = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(3);
		sda = 1'b1;
		tick(4);
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic recv(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, b[i]);
		end
		bit_io(last, s);
	endtask
	// Mode 1 spoils the check byte and mode 2 leaves it out.
	task automatic wr(input logic [7:0] cmd, input logic [15:0] v,
		input int mode, output logic ack);
		logic [7:0] c;
		logic a;
		c = crc(crc(crc(crc(8'h00, WA), cmd), v[7:0]), v[15:8]);
		start();
		send(WA, ack);
		send(cmd, a);
		send(v[7:0], a);
		send(v[15:8], a);
		if (mode != 2) begin
			send(mode == 1 ? ~c : c, a);
		end
		stop();
	endtask
	task automatic rd(input logic [7:0] cmd, output logic [15:0] v,
		output logic ok);
		logic [7:0] c;
		logic a;
		start();
		send(WA, a);
		send(cmd, a);
		start();
		send(RA, a);
		recv(1'b0, v[7:0]);
		recv(1'b0, v[15:8]);
		recv(1'b1, c);
		stop();
		ok = c == crc(crc(crc(crc(crc(8'h00, WA), cmd), RA), v[7:0]),
			v[15:8]);
	endtask
endmodule

// *** tb_battery_gauge_register_bank.sv ***
module tb_battery_gauge_register_bank
	import gauge_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cell_mv_valid = 1'b0;
	logic track_valid = 1'b0;
	logic [15:0] cell_mv_in = 16'h0e10;
	logic [15:0] thermistor_sense_input = 16'h0b00;
	logic [9:0] track_permille = 10'h000;
	logic scl, sda, sda_out, sda_oe, sw, alarm_n, running, a;
	logic [15:0] v, x;
	wire logic sda_w = sda & ~sda_oe;
	int seed = 32'h391d;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	int k;
	localparam logic [7:0] RC [11] = '{CMD_THERM_B, CMD_TEMP, CMD_DIR,
		CMD_IMPED, CMD_LAG, CMD_PROF_SEL, CMD_LOW_CHG, CMD_LOW_V, CMD_PWR,
		CMD_TSRC, CMD_PROF_CODE};
	localparam logic [15:0] RV [11] = '{16'h0d34, 16'h0ba6, 16'h0000,
		16'h0000, 16'h001e, 16'h0000, 16'h0008, 16'h0000, 16'h0001,
		16'h0000, 16'h0301};
	localparam logic [7:0] WC [18] = '{CMD_DIR, CMD_DIR, CMD_DIR, CMD_DIR,
		CMD_PROF_SEL, CMD_PROF_SEL, CMD_LOW_CHG, CMD_LOW_CHG, CMD_LOW_CHG,
		CMD_LOW_CHG, CMD_LOW_V, CMD_LOW_V, CMD_TEMP, CMD_TEMP, CMD_TEMP,
		CMD_TEMP, CMD_PROF_CODE, CMD_VERSION};
	localparam logic [15:0] WD [18] = '{16'h0001, 16'hffff, 16'h0002,
		16'h0000, 16'h0001, 16'h0002, 16'h0064, 16'h0065, 16'h0000,
		16'h0008, 16'hffff, 16'h0000, 16'h09e4, 16'h09e3, 16'h0d04,
		16'h0d05, 16'h0504, 16'h1234};
	localparam logic [15:0] WE [18] = '{16'h0001, 16'hffff, 16'hffff,
		16'h0000, 16'h0001, 16'h0001, 16'h0064, 16'h0064, 16'h0000,
		16'h0008, 16'hffff, 16'h0000, 16'h09e4, 16'h09e4, 16'h0d04,
		16'h0d04, 16'h0301, 16'h0001};
	localparam logic [15:0] DD [5] = '{DIR_CHARGE, DIR_CHARGE,
		DIR_DISCHARGE, DIR_DISCHARGE, DIR_AUTO};
	localparam logic [9:0] DT [5] = '{10'h12c, 10'h384, 10'h3b6, 10'h190,
		10'h258};
	localparam logic [15:0] DE [5] = '{16'h0352, 16'h0384, 16'h0384,
		16'h0190, 16'h0258};
	battery_gauge_register_bank #(
		.POR_CYCLES(50), .MS_CYCLES(10), .PERIOD_MS(4)
	) i_battery_gauge_register_bank (
		.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .cell_mv_in(cell_mv_in),
		.cell_mv_valid(cell_mv_valid),
		.thermistor_sense_input(thermistor_sense_input),
		.track_permille(track_permille), .track_valid(track_valid),
		.thermistor_power_switch(sw), .alarm_out_n(alarm_n),
		.gauge_running(running)
	);
	gauge_host_model i_gauge_host_model (
		.mclk(mclk), .sda_in(sda_w), .scl(scl), .sda(sda)
	);
	always #50 mclk = ~mclk;
	function automatic logic [15:0] pm(input logic [15:0] mv);
		if (mv <= MV_EMPTY) return 16'h0000;
		if (mv >= MV_FULL) return 16'h03e8;
		return (mv - MV_EMPTY) * 16'h000a / 16'h000c;
	endfunction
	function automatic logic [15:0] pct(input logic [15:0] p);
		return (p + 16'h0005) / 16'h000a;
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic w(input logic [7:0] c, input logic [15:0] d);
		i_gauge_host_model.wr(c, d, 0, a);
		check("addr ack", 16'(a), 16'h0001);
	endtask
	task automatic r(input logic [7:0] c, input logic [15:0] e);
		logic ok;
		i_gauge_host_model.rd(c, v, ok);
		check("crc", 16'(ok), 16'h0001);
		check($sformatf("reg %h", c), v, e);
	endtask
	task automatic mv(input logic [15:0] d);
		cell_mv_in = d;
		cell_mv_valid = 1'b1;
		@(negedge mclk);
		cell_mv_valid = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 90000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		w(CMD_PWR, PWR_OP);
		for (k = 0; k < 11; k++) begin
			r(RC[k], RV[k]);
		end
		r(CMD_PERMILLE, pm(16'h0e10));
		r(CMD_PCT, pct(pm(16'h0e10)));
		check("sda out", 16'(sda_out), 16'h0000);
		$display("test reset values done");
		for (k = 0; k < 4; k++) begin
			x = 16'($random(seed));
			w(CMD_THERM_B, x);
			r(CMD_THERM_B, x);
			w(CMD_LAG, ~x);
			r(CMD_LAG, ~x);
			x = MV_EMPTY + 16'(x[8:0]);
			mv(x);
			r(CMD_VOLT, x);
		end
		for (k = 0; k < 18; k++) begin
			w(WC[k], WD[k]);
			r(WC[k], WE[k]);
		end
		for (k = 1; k < 3; k++) begin
			i_gauge_host_model.wr(CMD_LOW_CHG, 16'h0020, k, a);
			r(CMD_LOW_CHG, 16'h0008);
		end
		$display("test register access done");
		// The cell rests while it is initialised, so it shows its OPEN_CIRCUIT_VOLTAGE.
		mv(16'h0ec4);
		w(CMD_IMM_INIT, INIT_KEY);
		r(CMD_PERMILLE, pm(16'h0ec4));
		r(CMD_PCT, pct(pm(16'h0ec4)));
		mv(16'h0e10);
		w(CMD_IMM_INIT, 16'haa54);
		r(CMD_PERMILLE, pm(16'h0ec4));
		mv(16'h0fb4);
		mv(16'h0e10);
		w(CMD_SAMPLED_INIT, INIT_KEY);
		r(CMD_PERMILLE, pm(16'h0fb4));
		for (k = 0; k < 5; k++) begin
			w(CMD_DIR, DD[k]);
			track_permille = DT[k];
			track_valid = 1'b1;
			@(negedge mclk);
			track_valid = 1'b0;
			r(CMD_PERMILLE, DE[k]);
		end
		$display("test charge state done");
		w(CMD_LOW_CHG, 16'h003d);
		check("alarm", 16'(alarm_n), 16'h0000);
		w(CMD_LOW_CHG, 16'h003c);
		check("alarm", 16'(alarm_n), 16'h0000);
		w(CMD_LOW_CHG, 16'h003b);
		check("alarm", 16'(alarm_n), 16'h0001);
		w(CMD_LOW_CHG, 16'h0000);
		w(CMD_LOW_V, 16'h0d48);
		mv(16'h0ce4);
		check("alarm", 16'(alarm_n), 16'h0000);
		mv(16'h0dac);
		check("alarm", 16'(alarm_n), 16'h0001);
		$display("test alarm done");
		thermistor_sense_input = TEMP_MIN + 16'(x[7:0]);
		w(CMD_LAG, 16'h0000);
		w(CMD_TSRC, TSRC_THERM);
		k = 0;
		while (sw !== 1'b1 && k < 400) begin
			@(negedge mclk);
			k++;
		end
		check("switch on", 16'(sw), 16'h0001);
		while (sw !== 1'b0 && k < 800) begin
			@(negedge mclk);
			k++;
		end
		check("switch pulse", 16'(k < 800), 16'h0001);
		r(CMD_TEMP, thermistor_sense_input);
		w(CMD_TSRC, TSRC_HOST);
		repeat (50) @(negedge mclk);
		k = 0;
		repeat (100) begin
			@(negedge mclk);
			k += int'(sw !== 1'b0);
		end
		check("switch idle", 16'(k), 16'h0000);
		// Back in host mode the host rewrites a one-degree change.
		w(CMD_TEMP, 16'h0ab6);
		r(CMD_TEMP, 16'h0ab6);
		$display("test thermistor done");
		w(CMD_PWR, PWR_SLEEP);
		check("running", 16'(running), 16'h0000);
		mv(16'h0f3c);
		r(CMD_VOLT, 16'h0dac);
		w(CMD_PWR, PWR_OP);
		check("running", 16'(running), 16'h0001);
		$display("test power mode done");
		summarize();
	end
endmodule
